// ==== hw/mmb_bus_ctrl.sv ====
`timescale 1ns/1ps

// Summary of operation
// - NMI edge serviced as interrupt type 2
// - NMI synchronized; taken at instruction end
// - NMI cannot be masked by software
// - Reset aborts bus activity at once
// - Reset synchronized; restart after it falls
// - Mode strap high selects minimum mode
// - IO select high for IO, low memory
// - IO select valid from preceding T4 or Ti
// - Write strobe low in T2, T3, Tw
// - Acknowledge strobe low in T2, T3, Tw
// - Latch pulse high in T1 low phase
// - Latch pulse always driven, never floated
// - Direction high transmit, timed like IO select
// - Read enable mid T2 to mid T4
// - Write enable start T2 to mid T4
// - IO select, write strobe, direction and enable float during hold grant
// - Grant hold mid T4 or Ti
module mmb_bus_ctrl (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              reset_pin,
  input  wire logic              nmi_pin,
  input  wire logic              mode_strap,
  input  wire logic              hold_req,
  input  wire logic              cycle_req,
  input  wire mmb_pkg::mmb_kind_t cycle_kind,
  input  wire logic              wait_req,
  input  wire logic              instr_boundary,
  output logic                   cycle_ack,
  output logic                   core_reset,
  output logic                   restart_pulse,
  output logic                   nmi_take,
  output logic [7:0]             nmi_type,
  output logic                   hold_grant,
  output logic                   min_mode,
  output logic                   addr_latch_pulse,
  output logic                   irq_ack_strobe_n,
  output logic                   mem_or_io_sel,
  output logic                   mem_or_io_sel_oe,
  output logic                   write_strobe_n,
  output logic                   write_strobe_n_oe,
  output logic                   xcvr_direction,
  output logic                   xcvr_direction_oe,
  output logic                   xcvr_enable_n,
  output logic                   xcvr_enable_n_oe
);
  import mmb_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic kind_is_io(input mmb_kind_t k);
    return (k == K_IO_RD) || (k == K_IO_WR);
  endfunction : kind_is_io

  function automatic logic kind_is_wr(input mmb_kind_t k);
    return (k == K_MEM_WR) || (k == K_IO_WR);
  endfunction : kind_is_wr

  function automatic logic in_strobe(input mmb_state_t s);
    return (s == ST_T2) || (s == ST_T3) || (s == ST_TW);
  endfunction : in_strobe

  // ------------------------------------------------------------
  // Pin synchronizers
  // ------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       rst_s;
  logic       nmi_s;
  logic       strap_s;
  logic       hold_s;
  logic       rst_q;
  logic       nmi_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {hold_req, mode_strap, nmi_pin, reset_pin};
      sync2 <= sync1;
    end
  end

  assign rst_s   = sync2[0];
  assign nmi_s   = sync2[1];
  assign strap_s = sync2[2];
  assign hold_s  = sync2[3];

  // ------------------------------------------------------------
  // Processor clock phase divider
  // ------------------------------------------------------------
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic       cpu_end;

  assign cpu_end = (ph == PH_LAST);
  assign next_ph = cpu_end ? PH_HIGH : ph + 2'h1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) ph <= PH_HIGH;
    else        ph <= next_ph;
  end

  // ------------------------------------------------------------
  // Reset, restart and mode
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_q         <= 1'b0;
      core_reset    <= 1'b0;
      restart_pulse <= 1'b0;
      min_mode      <= MIN_MODE_RST;
    end else begin
      rst_q         <= rst_s;
      core_reset    <= rst_s;
      restart_pulse <= rst_q & ~rst_s;
      if (rst_s) min_mode <= strap_s;
    end
  end

  // ------------------------------------------------------------
  // Non-maskable interrupt
  // ------------------------------------------------------------
  logic nmi_edge;
  logic nmi_pending;
  logic nmi_fire;

  assign nmi_edge = nmi_s & ~nmi_q;
  assign nmi_fire = nmi_pending & instr_boundary & ~rst_s;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_q       <= 1'b0;
      nmi_pending <= 1'b0;
      nmi_take    <= 1'b0;
      nmi_type    <= 8'h00;
    end else begin
      nmi_q       <= nmi_s;
      nmi_pending <= nmi_edge | (nmi_pending & ~nmi_fire & ~rst_s);
      nmi_take    <= nmi_fire;
      nmi_type    <= NMI_TYPE;
    end
  end

  // ------------------------------------------------------------
  // Bus cycle state machine
  // ------------------------------------------------------------
  mmb_state_t state;
  mmb_state_t next_state;
  mmb_kind_t  kind;
  mmb_kind_t  next_kind;
  logic       go;
  logic       next_go;
  logic       next_grant;
  logic       edge_state;
  logic       accept;
  logic       grant_point;

  assign edge_state  = (state == ST_TI) || (state == ST_T4);
  assign accept      = edge_state && (ph == PH_HIGH) && cycle_req && !go &&
                       !hold_grant && !hold_s && min_mode && !rst_s;
  assign next_kind   = accept ? cycle_kind : kind;
  assign next_go     = rst_s ? 1'b0 : (accept | (go & ~cpu_end));
  assign grant_point = edge_state && (ph == PH_LOW1) && !go;
  assign next_grant  = rst_s ? 1'b0 :
                       (grant_point ? hold_s : hold_grant);

  always_comb begin
    next_state = state;
    if (rst_s) begin
      next_state = ST_TI;
    end else if (cpu_end) begin
      unique case (state)
        ST_TI:   next_state = go ? ST_T1 : ST_TI;
        ST_T1:   next_state = ST_T2;
        ST_T2:   next_state = ST_T3;
        ST_T3:   next_state = wait_req ? ST_TW : ST_T4;
        ST_TW:   next_state = wait_req ? ST_TW : ST_T4;
        ST_T4:   next_state = go ? ST_T1 : ST_TI;
        default: next_state = ST_TI;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= ST_TI;
      kind       <= K_MEM_RD;
      go         <= 1'b0;
      hold_grant <= 1'b0;
      cycle_ack  <= 1'b0;
    end else begin
      state      <= next_state;
      kind       <= next_kind;
      go         <= next_go;
      hold_grant <= next_grant;
      cycle_ack  <= accept;
    end
  end

  // ------------------------------------------------------------
  // Strobe decode from next state
  // ------------------------------------------------------------
  logic n_wr;
  logic n_strobe;
  logic n_ale;
  logic n_den;
  logic n_oe;

  assign n_wr     = kind_is_wr(next_kind);
  assign n_strobe = in_strobe(next_state);
  assign n_ale    = min_mode && (next_state == ST_T1) &&
                    (next_ph != PH_HIGH);
  assign n_den    = (next_state == ST_T3) || (next_state == ST_TW) ||
                    ((next_state == ST_T2) &&
                     (n_wr || (next_ph != PH_HIGH))) ||
                    ((next_state == ST_T4) && (next_ph == PH_HIGH));
  assign n_oe     = min_mode && !next_grant;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_latch_pulse  <= 1'b0;
      irq_ack_strobe_n  <= 1'b1;
      mem_or_io_sel     <= 1'b0;
      write_strobe_n    <= 1'b1;
      xcvr_direction    <= 1'b0;
      xcvr_enable_n     <= 1'b1;
      mem_or_io_sel_oe  <= 1'b0;
      write_strobe_n_oe <= 1'b0;
      xcvr_direction_oe <= 1'b0;
      xcvr_enable_n_oe  <= 1'b0;
    end else begin
      addr_latch_pulse  <= n_ale;
      irq_ack_strobe_n  <= ~(n_strobe && (next_kind == K_IRQ_ACK_STROBE_N));
      mem_or_io_sel     <= kind_is_io(next_kind);
      write_strobe_n    <= ~(n_strobe && n_wr);
      xcvr_direction    <= n_wr;
      xcvr_enable_n     <= ~n_den;
      mem_or_io_sel_oe  <= n_oe;
      write_strobe_n_oe <= n_oe;
      xcvr_direction_oe <= n_oe;
      xcvr_enable_n_oe  <= n_oe;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ale_low_phase: assert property (
    addr_latch_pulse |-> (state == ST_T1) && (ph != PH_HIGH))
    else $error("latch pulse outside T1 low phase");

  chk_ale_t1_pulse: assert property (
    (state == ST_T1) && (ph == PH_HIGH) && min_mode && !rst_s
    |=> addr_latch_pulse [*2] ##1 !addr_latch_pulse)
    else $error("latch pulse not two cycles in T1");

  chk_wr_window: assert property (
    !write_strobe_n |-> in_strobe(state) && kind_is_wr(kind))
    else $error("write strobe outside window");

  chk_irq_ack_strobe_n_window: assert property (
    (in_strobe(state) && kind == K_IRQ_ACK_STROBE_N) == !irq_ack_strobe_n)
    else $error("acknowledge strobe mismatch");

  chk_den_read_start: assert property (
    (state == ST_T2) && !kind_is_wr(kind) |->
    (ph == PH_HIGH) == xcvr_enable_n)
    else $error("read enable not from mid T2");

  chk_den_write_start: assert property (
    (state == ST_T2) && kind_is_wr(kind) |-> !xcvr_enable_n)
    else $error("write enable not from start of T2");

  chk_den_t4_end: assert property (
    (state == ST_T4) && (ph != PH_HIGH) |-> xcvr_enable_n)
    else $error("enable beyond mid T4");

  chk_float_grant: assert property (
    hold_grant |-> !mem_or_io_sel_oe && !write_strobe_n_oe &&
    !xcvr_direction_oe && !xcvr_enable_n_oe)
    else $error("strobes driven during grant");

  chk_grant_point: assert property (
    $rose(hold_grant) |-> $past(ph) == PH_LOW1 && $past(hold_s))
    else $error("grant not at mid state");

  chk_abort_reset: assert property (
    rst_s |=> (state == ST_TI) && write_strobe_n && !hold_grant)
    else $error("bus not aborted on reset");

  chk_restart_seen: assert property (
    $fell(rst_s) |=> restart_pulse ##1 !restart_pulse)
    else $error("no restart after reset");

  chk_nmi_take: assert property (
    nmi_edge && !rst_s ##1 instr_boundary && !rst_s
    |=> nmi_take && (nmi_type == NMI_TYPE))
    else $error("nmi edge not serviced");

  chk_sel_stable: assert property (
    !edge_state |=> $stable(mem_or_io_sel) && $stable(xcvr_direction))
    else $error("status changed mid cycle");

  chk_sel_encoding: assert property (
    !edge_state |-> mem_or_io_sel == kind_is_io(kind))
    else $error("memory or io select wrong");

  chk_dir_encoding: assert property (
    !edge_state |-> xcvr_direction == kind_is_wr(kind))
    else $error("direction wrong for cycle");

  chk_ale_in_grant: assert property (
    hold_grant |-> !addr_latch_pulse)
    else $error("latch pulse during grant");

  chk_nmi_unmasked: assert property (
    nmi_pending && instr_boundary && !rst_s |=> nmi_take)
    else $error("pending nmi not taken");

  chk_grant_release: assert property (
    hold_grant && !hold_s && edge_state && (ph == PH_LOW1) |=> !hold_grant)
    else $error("grant kept after hold dropped");

  chk_oe_max_mode: assert property (
    !min_mode |=> !mem_or_io_sel_oe && !write_strobe_n_oe &&
    !xcvr_direction_oe && !xcvr_enable_n_oe)
    else $error("strobes driven in maximum mode");

  cov_write_cycle: cover property (
    (state == ST_T1) && kind_is_wr(kind) ##[1:20] !write_strobe_n);
  cov_wait_state: cover property (state == ST_TW);
  cov_hold_grant: cover property ($rose(hold_grant));
  cov_nmi_taken: cover property (nmi_take);

endmodule : mmb_bus_ctrl

// ==== hw/mmb_pkg.sv ====
package mmb_pkg;

  // ------------------------------------------------------------
  // Processor clock phases (one third high)
  // ------------------------------------------------------------
  localparam logic [1:0] PH_HIGH  = 2'h0;
  localparam logic [1:0] PH_LOW1  = 2'h1;
  localparam logic [1:0] PH_LAST  = 2'h2;
  localparam int         SYS_CLK_NS     = 4;
  localparam int         CPU_CLK_NS     = 12;
  localparam int         CPU_CLK_CYCLES = CPU_CLK_NS / SYS_CLK_NS;

  // ------------------------------------------------------------
  // Interrupt vector
  // ------------------------------------------------------------
  localparam logic [7:0] NMI_TYPE = 8'h02;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic       MIN_MODE_RST = 1'b1;

  // ------------------------------------------------------------
  // Bus states and cycle kinds
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_TI = 3'h0,
    ST_T1 = 3'h1,
    ST_T2 = 3'h2,
    ST_T3 = 3'h3,
    ST_TW = 3'h4,
    ST_T4 = 3'h5
  } mmb_state_t;

  typedef enum logic [2:0] {
    K_MEM_RD = 3'h0,
    K_MEM_WR = 3'h1,
    K_IO_RD  = 3'h2,
    K_IO_WR  = 3'h3,
    K_IRQ_ACK_STROBE_N   = 3'h4
  } mmb_kind_t;

endpackage : mmb_pkg

// ==== testbench/min_mode_bus_control_bench.sv ====
`timescale 1ns/1ps

module min_mode_bus_control_bench;
  import mmb_pkg::*;
  logic sys_clk = 0, rst_n = 0, reset_pin = 0, nmi_pin = 0, mode_strap = 1;
  logic hold_req = 0, cycle_req = 0, instr_boundary = 0, slow = 0, wait_req;
  mmb_kind_t cycle_kind = K_MEM_RD;
  logic cycle_ack, core_reset, restart_pulse, nmi_take, hold_grant, min_mode;
  logic [7:0] nmi_type;
  logic addr_latch_pulse, irq_ack_strobe_n, mem_or_io_sel, mem_or_io_sel_oe;
  logic write_strobe_n, write_strobe_n_oe, xcvr_direction, xcvr_direction_oe;
  logic xcvr_enable_n, xcvr_enable_n_oe;
  int   n_errors = 0, n_compared = 0, seed = 32'h78b1;

  mmb_bus_ctrl dut (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .reset_pin         (reset_pin),
    .nmi_pin           (nmi_pin),
    .mode_strap        (mode_strap),
    .hold_req          (hold_req),
    .cycle_req         (cycle_req),
    .cycle_kind        (cycle_kind),
    .wait_req          (wait_req),
    .instr_boundary    (instr_boundary),
    .cycle_ack         (cycle_ack),
    .core_reset        (core_reset),
    .restart_pulse     (restart_pulse),
    .nmi_take          (nmi_take),
    .nmi_type          (nmi_type),
    .hold_grant        (hold_grant),
    .min_mode          (min_mode),
    .addr_latch_pulse  (addr_latch_pulse),
    .irq_ack_strobe_n  (irq_ack_strobe_n),
    .mem_or_io_sel     (mem_or_io_sel),
    .mem_or_io_sel_oe  (mem_or_io_sel_oe),
    .write_strobe_n    (write_strobe_n),
    .write_strobe_n_oe (write_strobe_n_oe),
    .xcvr_direction    (xcvr_direction),
    .xcvr_direction_oe (xcvr_direction_oe),
    .xcvr_enable_n     (xcvr_enable_n),
    .xcvr_enable_n_oe  (xcvr_enable_n_oe)
  );

  mmb_far_model far (
    .sys_clk          (sys_clk),
    .addr_latch_pulse (addr_latch_pulse),
    .slow             (slow),
    .wait_req         (wait_req)
  );

  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic await(ref logic s);
    int t = 0;
    while (s !== 1'b1 && t < 40) begin
      tick;
      t++;
    end
    chk(s, 1);
  endtask : await

  task give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  function int strobe_len(input logic on, input int w);
    return on ? 6 + 3 * w : 0;
  endfunction : strobe_len

  task boot(input logic strap);
    reset_pin = 1;
    mode_strap = strap;
    repeat (14) tick;
    chk(core_reset, 1);
    reset_pin = 0;
    await(restart_pulse);
    chk(min_mode, strap);
    chk({mem_or_io_sel_oe, write_strobe_n_oe, xcvr_direction_oe,
         xcvr_enable_n_oe}, {4{strap}});
  endtask : boot

  task run_cyc(input mmb_kind_t k, input logic s);
    int a, wr, ia, en, bad, w;
    logic sel, iswr;
    a = 0; wr = 0; ia = 0; en = 0; bad = 0; w = s;
    sel = (k == K_IO_RD || k == K_IO_WR);
    iswr = (k == K_MEM_WR || k == K_IO_WR);
    slow = s;
    cycle_kind = k;
    cycle_req = 1;
    await(cycle_ack);
    cycle_req = 0;
    chk(xcvr_direction, iswr);
    repeat (30) begin
      bad += (mem_or_io_sel !== sel);
      a += (addr_latch_pulse === 1'b1);
      wr += (write_strobe_n === 1'b0);
      ia += (irq_ack_strobe_n === 1'b0);
      en += (xcvr_enable_n === 1'b0);
      tick;
    end
    chk(bad, 0);
    chk(a, 2);
    chk(wr, strobe_len(iswr, w));
    chk(ia, strobe_len(k == K_IRQ_ACK_STROBE_N, w));
    chk(en, strobe_len(1, w) + iswr);
  endtask : run_cyc

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) tick;
    rst_n = 1;
    boot(1);
    repeat (12) begin
      run_cyc(mmb_kind_t'($unsigned($random(seed)) % 5),
              ($random(seed) & 1) != 0);
    end
    run_cyc(K_IO_WR, 1);
    run_cyc(K_IRQ_ACK_STROBE_N, 1);
    run_cyc(K_IO_RD, 0);
    run_cyc(K_MEM_WR, 0);
    hold_req = 1;
    await(hold_grant);
    chk({mem_or_io_sel_oe, write_strobe_n_oe, xcvr_direction_oe,
         xcvr_enable_n_oe}, 0);
    chk(addr_latch_pulse, 0);
    cycle_req = 1;
    repeat (9) begin
      chk(cycle_ack, 0);
      tick;
    end
    hold_req = 0;
    await(cycle_ack);
    cycle_req = 0;
    chk(hold_grant, 0);
    repeat (30) tick;
    instr_boundary = 1;
    nmi_pin = 1;
    await(nmi_take);
    chk(nmi_type, NMI_TYPE);
    nmi_pin = 0;
    instr_boundary = 0;
    repeat (4) tick;
    nmi_pin = 1;
    repeat (8) begin
      chk(nmi_take, 0);
      tick;
    end
    instr_boundary = 1;
    await(nmi_take);
    chk(nmi_type, 8'h02);
    instr_boundary = 0;
    nmi_pin = 0;
    cycle_kind = K_MEM_WR;
    cycle_req = 1;
    await(cycle_ack);
    cycle_req = 0;
    repeat (7) tick;
    reset_pin = 1;
    repeat (3) tick;
    chk({write_strobe_n, irq_ack_strobe_n, xcvr_enable_n,
         addr_latch_pulse}, 8'h0E);
    boot(0);
    cycle_req = 1;
    repeat (20) begin
      chk(cycle_ack, 0);
      tick;
    end
    cycle_req = 0;
    boot(1);
    run_cyc(K_MEM_RD, 0);
    give_verdict;
  end

  initial begin
    #60000;
    n_errors++;
    give_verdict;
  end
endmodule : min_mode_bus_control_bench

// ==== testbench/mmb_far_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Address latch and slow memory
// ----------------------------------------
module mmb_far_model (
  input  wire logic       sys_clk,
  input  wire logic       addr_latch_pulse,
  input  wire logic       slow,
  output logic            wait_req
);
  logic [3:0] cnt = 4'h0;
  logic       seen = 1'b0;

  // Latch strobe marks a new cycle
  always_ff @(posedge sys_clk) begin
    seen <= addr_latch_pulse;
    if (addr_latch_pulse && !seen) begin
      cnt <= slow ? 4'h7 : 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end

  // Slow device holds one wait state
  assign wait_req = (cnt != 4'h0);
endmodule : mmb_far_model
